// ### rtl/cdio_line.sv
// One I/O line: polarity, direction and source routing.
// Assumes pin inputs are already synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
module cdio_line
  import cdio_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   is_phys,
  input  wire logic                   dir_out,
  input  wire logic                   flip,
  input  wire logic [CDIO_SRC_W-1:0]  src,
  input  wire logic [CDIO_UOUT_W-1:0] soft_word,
  input  wire logic [CDIO_NSRC-1:0]   int_sig,
  input  wire logic                   pin_in,
  output logic                        pin_out,
  output logic                        pin_oe,
  output logic                        level
);
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
    logic level;
  } cdio_line_st_t;

  cdio_line_st_t st;
  cdio_line_st_t next_st;
  logic          raw;
  logic [CDIO_SRC_W-1:0] rel;

  // Source mux, then polarity; virtual lines never drive the connector
  always_comb begin
    rel = src - CDIO_SRC_USER0;
    raw = 1'b0;
    if (src == CDIO_SRC_OFF) begin
      raw = 1'b0;
    end else if (src < CDIO_SRC_INT0) begin
      raw = soft_word[rel[CDIO_UBIT_W-1:0]]; // R6
    end else begin
      rel = src - CDIO_SRC_INT0;
      raw = int_sig[rel[CDIO_UBIT_W-1:0]]; // R6
    end
    next_st.pin_oe  = dir_out & is_phys; // R2
    next_st.pin_out = raw ^ flip; // R3
    // Level seen by status is the inverted input or the driven output
    next_st.level   = next_st.pin_oe ? next_st.pin_out : (pin_in ^ flip); // R11
  end

  // Registered so the pins come straight from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_out = st.pin_out;
  assign pin_oe  = st.pin_oe;
  assign level   = st.level;

  chk_out_polarity: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (src == CDIO_SRC_OFF) |=> (pin_out == $past(flip)))
    else $error("line output polarity wrong");
  chk_virt_no_drive: assert property (@(posedge pclk) disable iff (!presetn) // R2
    !is_phys |=> !pin_oe)
    else $error("virtual line drove the pin");
endmodule : cdio_line
`default_nettype wire

// ### rtl/cdio_pkg.sv
// Constants, register map and types for the camera digital I/O line block.
// Assumes one APB clock domain; line inputs arrive synchronous to pclk.
// Operation
// R1: Selector picks one physical or virtual line
// R2: Physical line direction is input or output
// R3: Per-line flag inverts input or output signal
// R4: Read-only bit shows selected line level
// R5: One word returns all line levels now
// R6: Output line drives selected internal source
// R7: Bit pick plus bit write updates one bit
// R8: Whole user output word readable and writable
// R9: Mask applied before whole-word write stored
// R10: Only mask-one bits change on word write
// R11: Inputs pass inversion before status reporting
package cdio_pkg;
  localparam int          CDIO_PHYS_LINES = 8;
  localparam int          CDIO_VIRT_LINES = 4;
  localparam int          CDIO_LINES      = CDIO_PHYS_LINES + CDIO_VIRT_LINES;
  localparam int          CDIO_SEL_W      = 4;
  localparam int          CDIO_SRC_W      = 4;
  localparam int          CDIO_NSRC       = 8;
  localparam int          CDIO_UOUT_W     = 8;
  localparam int          CDIO_UBIT_W     = 3;

  // Byte offsets of the APB registers
  localparam logic [11:0] CDIO_OFS_PIN_PICK    = 12'h000;
  localparam logic [11:0] CDIO_OFS_PIN_CFG     = 12'h004;
  localparam logic [11:0] CDIO_OFS_PIN_LEVEL   = 12'h008;
  localparam logic [11:0] CDIO_OFS_ALL_LEVELS  = 12'h00C;
  localparam logic [11:0] CDIO_OFS_SOFT_PICK   = 12'h010;
  localparam logic [11:0] CDIO_OFS_SOFT_LEVEL  = 12'h014;
  localparam logic [11:0] CDIO_OFS_SOFT_WORD   = 12'h018;
  localparam logic [11:0] CDIO_OFS_SOFT_MASK   = 12'h01C;

  // Field positions inside the per-line configuration word
  localparam int          CDIO_CFG_DIR_BIT     = 0;
  localparam int          CDIO_CFG_FLIP_BIT    = 1;
  localparam int          CDIO_CFG_SRC_LSB     = 4;

  // Values after reset
  localparam logic [CDIO_UOUT_W-1:0] CDIO_MASK_RST = 8'hFF;
  localparam logic [CDIO_SRC_W-1:0]  CDIO_SRC_RST  = 4'h0;

  // Output source codes: 0 selects a constant low, 1..8 pick a user output bit, 9..F internal
  localparam logic [CDIO_SRC_W-1:0]  CDIO_SRC_OFF   = 4'h0;
  localparam logic [CDIO_SRC_W-1:0]  CDIO_SRC_USER0 = 4'h1;
  localparam logic [CDIO_SRC_W-1:0]  CDIO_SRC_INT0  = 4'h9;

  typedef enum logic {CDIO_DIR_IN, CDIO_DIR_OUT} cdio_dir_t;
endpackage : cdio_pkg

// ### rtl/cdio_top.sv
// Digital I/O line block: APB registers, per-line config and user outputs.
// Assumes a single pclk domain; pin inputs synchronous; zero-wait APB slave.
`timescale 1ns/100ps
`default_nettype none
module cdio_top
  import cdio_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic                        pready,
  output logic                        pslverr,
  output logic [31:0]                 prdata,
  input  wire logic [CDIO_PHYS_LINES-1:0] pin_in,
  output logic [CDIO_PHYS_LINES-1:0]  pin_out,
  output logic [CDIO_PHYS_LINES-1:0]  pin_oe,
  input  wire logic [CDIO_VIRT_LINES-1:0] virt_in,
  output logic [CDIO_VIRT_LINES-1:0]  virt_out,
  input  wire logic [CDIO_NSRC-1:0]   int_sig,
  output logic [CDIO_UOUT_W-1:0]      soft_out
);
  typedef struct packed {
    logic [CDIO_SEL_W-1:0]               io_pin_pick;
    logic [CDIO_LINES-1:0]               io_pin_direction;
    logic [CDIO_LINES-1:0]               io_pin_polarity_flip;
    logic [CDIO_LINES-1:0][CDIO_SRC_W-1:0] io_pin_output_origin;
    logic [CDIO_UBIT_W-1:0]              soft_out_bit_pick;
    logic [CDIO_UOUT_W-1:0]              soft_out_word;
    logic [CDIO_UOUT_W-1:0]              soft_out_write_mask;
    logic [31:0]                         prdata;
    logic                                pslverr;
    logic                                pready;
  } cdio_st_t;

  cdio_st_t st;
  cdio_st_t next_st;
  logic [CDIO_LINES-1:0] line_in;
  logic [CDIO_LINES-1:0] line_out;
  logic [CDIO_LINES-1:0] line_oe;
  logic [CDIO_LINES-1:0] all_pins_level_word;
  logic                  wr;
  logic                  rd;
  logic                  sel_ok;
  logic [CDIO_SEL_W-1:0] pk;
  logic                  full_word;
  logic                  setup;

  assign line_in = {virt_in, pin_in};
  assign wr      = psel & penable & pwrite;
  assign rd      = psel & penable & ~pwrite;
  assign pk      = st.io_pin_pick;
  assign sel_ok  = (pk < CDIO_SEL_W'(CDIO_LINES));
  assign full_word = (pstrb == 4'hF);
  assign setup     = psel & ~penable; // Setup cycle of a transfer

  // One line cell per physical and virtual line
  generate
    for (genvar i = 0; i < CDIO_LINES; i++) begin : g_line
      cdio_line u_line (
        .pclk      (pclk),
        .presetn   (presetn),
        .is_phys   (i < CDIO_PHYS_LINES),
        .dir_out   (st.io_pin_direction[i]),
        .flip      (st.io_pin_polarity_flip[i]),
        .src       (st.io_pin_output_origin[i]),
        .soft_word (st.soft_out_word),
        .int_sig   (int_sig),
        .pin_in    (line_in[i]),
        .pin_out   (line_out[i]),
        .pin_oe    (line_oe[i]),
        .level     (all_pins_level_word[i])
      );
    end
  endgenerate

  // Register writes and read mux; a write needs all four strobes
  always_comb begin
    next_st         = st;
    next_st.pslverr = 1'b0;
    next_st.pready  = setup; // Zero-wait: ready stands through the access
    // Errors decided in setup so they stand beside pready in the access
    if (setup && pwrite) begin
      case (paddr)
        CDIO_OFS_PIN_PICK, CDIO_OFS_SOFT_PICK, CDIO_OFS_SOFT_LEVEL,
        CDIO_OFS_SOFT_WORD, CDIO_OFS_SOFT_MASK: begin
          next_st.pslverr = ~full_word;
        end
        CDIO_OFS_PIN_CFG: begin
          next_st.pslverr = ~full_word | ~sel_ok;
        end
        default: begin
          next_st.pslverr = 1'b1; // Unmapped or read-only
        end
      endcase
    end
    // State changes land at the access edge only
    if (wr && full_word) begin
      case (paddr)
        CDIO_OFS_PIN_PICK: begin
          next_st.io_pin_pick = pwdata[CDIO_SEL_W-1:0]; // R1
        end
        CDIO_OFS_PIN_CFG: begin
          if (sel_ok) begin
            next_st.io_pin_direction[pk]     = pwdata[CDIO_CFG_DIR_BIT]; // R2
            next_st.io_pin_polarity_flip[pk] = pwdata[CDIO_CFG_FLIP_BIT]; // R3
            next_st.io_pin_output_origin[pk] =
              pwdata[CDIO_CFG_SRC_LSB +: CDIO_SRC_W]; // R6
          end
        end
        CDIO_OFS_SOFT_PICK: begin
          next_st.soft_out_bit_pick = pwdata[CDIO_UBIT_W-1:0]; // R7
        end
        CDIO_OFS_SOFT_LEVEL: begin
          next_st.soft_out_word[st.soft_out_bit_pick] = pwdata[0]; // R7
        end
        CDIO_OFS_SOFT_WORD: begin
          // Masked merge: mask-zero bits keep their old value
          next_st.soft_out_word = (st.soft_out_word & ~st.soft_out_write_mask)
            | (pwdata[CDIO_UOUT_W-1:0] & st.soft_out_write_mask); // R9 R10
        end
        CDIO_OFS_SOFT_MASK: begin
          next_st.soft_out_write_mask = pwdata[CDIO_UOUT_W-1:0]; // R9
        end
        default: begin
          next_st.soft_out_word = st.soft_out_word; // Read-only or unmapped
        end
      endcase
    end
    // Read data latched in setup so it stands at the completing edge
    next_st.prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        CDIO_OFS_PIN_PICK: begin
          next_st.prdata[CDIO_SEL_W-1:0] = st.io_pin_pick;
        end
        CDIO_OFS_PIN_CFG: begin
          if (sel_ok) begin
            next_st.prdata[CDIO_CFG_DIR_BIT]  = st.io_pin_direction[pk];
            next_st.prdata[CDIO_CFG_FLIP_BIT] = st.io_pin_polarity_flip[pk];
            next_st.prdata[CDIO_CFG_SRC_LSB +: CDIO_SRC_W] = st.io_pin_output_origin[pk];
          end
        end
        CDIO_OFS_PIN_LEVEL: begin
          if (sel_ok) begin
            next_st.prdata[0] = all_pins_level_word[pk]; // R4
          end
        end
        CDIO_OFS_ALL_LEVELS: begin
          next_st.prdata[CDIO_LINES-1:0] = all_pins_level_word; // R5
        end
        CDIO_OFS_SOFT_PICK: begin
          next_st.prdata[CDIO_UBIT_W-1:0] = st.soft_out_bit_pick;
        end
        CDIO_OFS_SOFT_LEVEL: begin
          next_st.prdata[0] = st.soft_out_word[st.soft_out_bit_pick];
        end
        CDIO_OFS_SOFT_WORD: begin
          next_st.prdata[CDIO_UOUT_W-1:0] = st.soft_out_word; // R8
        end
        CDIO_OFS_SOFT_MASK: begin
          next_st.prdata[CDIO_UOUT_W-1:0] = st.soft_out_write_mask;
        end
        default: begin
          next_st.pslverr = 1'b1;
        end
      endcase
    end
  end

  // Reset: all lines inputs, no inversion, mask fully open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                     <= '0;
      st.soft_out_write_mask <= CDIO_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // Zero-wait slave: ready, data and error all registered in setup
  assign pready   = st.pready;
  assign prdata   = st.prdata;
  assign pslverr  = st.pslverr;
  assign pin_out  = line_out[CDIO_PHYS_LINES-1:0];
  assign pin_oe   = line_oe[CDIO_PHYS_LINES-1:0];
  assign virt_out = line_out[CDIO_LINES-1:CDIO_PHYS_LINES];
  assign soft_out = st.soft_out_word;

  chk_bit_write: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (wr && full_word && paddr == CDIO_OFS_SOFT_LEVEL) |=>
    (soft_out[$past(st.soft_out_bit_pick)] == $past(pwdata[0])))
    else $error("single bit write lost");
  chk_mask_keep: assert property (@(posedge pclk) disable iff (!presetn) // R10
    (wr && full_word && paddr == CDIO_OFS_SOFT_WORD) |=>
    ((soft_out & ~$past(st.soft_out_write_mask)) ==
     ($past(soft_out) & ~$past(st.soft_out_write_mask))))
    else $error("masked bit changed");
  chk_mask_apply: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (wr && full_word && paddr == CDIO_OFS_SOFT_WORD) |=>
    ((soft_out & $past(st.soft_out_write_mask)) ==
     ($past(pwdata[CDIO_UOUT_W-1:0]) & $past(st.soft_out_write_mask))))
    else $error("unmasked bit not written");
  // Read checks sit in the access cycle, where the master takes the data
  chk_word_read: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (rd && paddr == CDIO_OFS_SOFT_WORD) |->
    (prdata[CDIO_UOUT_W-1:0] == soft_out))
    else $error("word readback wrong");
  chk_all_levels: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (rd && paddr == CDIO_OFS_ALL_LEVELS) |->
    (prdata[CDIO_LINES-1:0] == $past(all_pins_level_word)))
    else $error("all-levels read wrong");
  chk_pick_level: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (rd && paddr == CDIO_OFS_PIN_LEVEL && sel_ok) |->
    (prdata[0] == $past(all_pins_level_word[pk])))
    else $error("selected level read wrong");
  chk_in_flip: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (!st.io_pin_direction[0] && $stable(st.io_pin_polarity_flip[0])) |=>
    (all_pins_level_word[0] == ($past(pin_in[0]) ^ $past(st.io_pin_polarity_flip[0]))))
    else $error("input inversion wrong");
  chk_pick_store: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (wr && full_word && paddr == CDIO_OFS_PIN_PICK) |=>
    (st.io_pin_pick == $past(pwdata[CDIO_SEL_W-1:0])))
    else $error("line pick not stored");
  chk_dir_drive: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (st.io_pin_direction[0] && $stable(st.io_pin_direction[0])) |=> pin_oe[0])
    else $error("output line not driven");

  cov_word_write: cover property (@(posedge pclk) wr && paddr == CDIO_OFS_SOFT_WORD);
  cov_bit_write:  cover property (@(posedge pclk) wr && paddr == CDIO_OFS_SOFT_LEVEL);
  cov_level_read: cover property (@(posedge pclk) rd && paddr == CDIO_OFS_ALL_LEVELS);
  cov_out_line:   cover property (@(posedge pclk) pin_oe != '0);
endmodule : cdio_top
`default_nettype wire

// ### tb/cdio_pin_model.sv
// Far-side model of the connector: outside drivers meet the block's drivers.
// Assumes the bench chooses the outside level; the wire level feeds pin_in.
`timescale 1ns/100ps
`default_nettype none
module cdio_pin_model
  import cdio_pkg::*;
(
  input  wire logic [CDIO_PHYS_LINES-1:0] ext_lvl,
  input  wire logic [CDIO_PHYS_LINES-1:0] pin_out,
  input  wire logic [CDIO_PHYS_LINES-1:0] pin_oe,
  output logic      [CDIO_PHYS_LINES-1:0] pin_in
);
  // Driven lines carry the block's value, the rest the outside driver
  always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : cdio_pin_model
`default_nettype wire

// ### tb/tb_camera_digital_io_lines.sv
// Self-checking bench for the digital I/O line block.
// Assumes an APB slave; read data and error are taken at the edge pready is high.
`timescale 1ns/100ps
`default_nettype none
module tb_camera_digital_io_lines;
  import cdio_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, v, dv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, virt_in, virt_out;
  logic [7:0]  ext_lvl, pin_in, pin_out, pin_oe, int_sig, soft_out, exp_uo, m, w, cfg;
  logic [7:0]  cfg_a [CDIO_LINES];
  int          fail_count = 0;
  int          n_checks   = 0;
  int          seed       = 70199;
  int          cyc        = 0;
  int          l;

  cdio_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .virt_in(virt_in), .virt_out(virt_out), .int_sig(int_sig),
    .soft_out(soft_out));
  cdio_pin_model pins (.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // One APB transfer; data and error taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= wr ? s : 4'h0; // Reads carry no strobes
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait until pready is seen high; the hang guard ends the run if it never comes
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  // Value a line drives: source pick, then polarity
  function automatic logic drive_val(input logic [3:0] src, input logic flip);
    if (src == CDIO_SRC_OFF) return flip;
    if (src < CDIO_SRC_INT0) return exp_uo[src - CDIO_SRC_USER0] ^ flip;
    return int_sig[src - CDIO_SRC_INT0] ^ flip;
  endfunction : drive_val

  function automatic logic [CDIO_LINES-1:0] all_lvl();
    for (int j = 0; j < CDIO_LINES; j++) begin
      // Virtual lines never drive the connector, so they report their input
      if (cfg_a[j][0] && j < CDIO_PHYS_LINES) all_lvl[j] = drive_val(cfg_a[j][7:4], cfg_a[j][1]);
      else all_lvl[j] = (j < 8 ? ext_lvl[j] : virt_in[j-8]) ^ cfg_a[j][1];
    end
  endfunction : all_lvl

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {ext_lvl, virt_in, int_sig, exp_uo} = '0;
    for (int j = 0; j < CDIO_LINES; j++) cfg_a[j] = 8'h00;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CDIO_OFS_SOFT_MASK, 32'h0, 4'hF);
    chk("mask reset", {24'h0, CDIO_MASK_RST}, rd);
    chk("soft_out reset", 32'h0, soft_out);
    chk("pin_oe reset", 32'h0, pin_oe);
    $display("test reset done");
    // Single-bit writes touch only the picked bit
    for (int b = 0; b < CDIO_UOUT_W; b++) begin
      v = 1'($random(seed));
      apb(1'b1, CDIO_OFS_SOFT_PICK, b, 4'hF);
      apb(1'b1, CDIO_OFS_SOFT_LEVEL, {31'h0, v}, 4'hF);
      exp_uo[b] = v;
      settle();
      chk("soft_out bit", exp_uo, soft_out);
      apb(1'b0, CDIO_OFS_SOFT_LEVEL, 32'h0, 4'hF);
      chk("soft bit read", {31'h0, v}, rd);
    end
    $display("test bit writes done");
    // Masked word writes, corner masks first
    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
      w = 8'($random(seed));
      apb(1'b1, CDIO_OFS_SOFT_MASK, {24'h0, m}, 4'hF);
      apb(1'b1, CDIO_OFS_SOFT_WORD, {24'h0, w}, 4'hF);
      exp_uo = (exp_uo & ~m) | (w & m);
      apb(1'b0, CDIO_OFS_SOFT_WORD, 32'h0, 4'hF);
      settle();
      chk("soft word", exp_uo, rd[7:0]);
      chk("soft_out word", exp_uo, soft_out);
    end
    apb(1'b1, CDIO_OFS_SOFT_MASK, 32'hFF, 4'hF);
    $display("test masked writes done");
    // Every line twice with random direction, polarity, source and far-side levels
    for (int i = 0; i < 2 * CDIO_LINES; i++) begin
      l   = i % CDIO_LINES;
      cfg = 8'($random(seed)) & 8'hF3;
      ext_lvl <= 8'($random(seed));
      virt_in <= 4'($random(seed));
      int_sig <= 8'($random(seed));
      apb(1'b1, CDIO_OFS_PIN_PICK, l, 4'hF);
      apb(1'b1, CDIO_OFS_PIN_CFG, {24'h0, cfg}, 4'hF);
      cfg_a[l] = cfg;
      settle();
      dv = drive_val(cfg[7:4], cfg[1]);
      if (l < CDIO_PHYS_LINES) begin
        chk("pin_oe", cfg[0], pin_oe[l]);
        if (cfg[0]) chk("pin_out", dv, pin_out[l]);
      end else begin
        chk("virt_out", dv, virt_out[l-8]);
      end
      apb(1'b0, CDIO_OFS_PIN_CFG, 32'h0, 4'hF);
      chk("line cfg", cfg, rd[7:0]);
      apb(1'b0, CDIO_OFS_PIN_PICK, 32'h0, 4'hF);
      chk("line pick", l, rd);
      apb(1'b0, CDIO_OFS_PIN_LEVEL, 32'h0, 4'hF);
      chk("picked level", all_lvl() >> l & 1, rd[0]);
      apb(1'b0, CDIO_OFS_ALL_LEVELS, 32'h0, 4'hF);
      chk("all levels", all_lvl(), rd[11:0]);
    end
    $display("test lines done");
    // Refused accesses leave the state alone
    apb(1'b1, 12'h020, 32'h0, 4'hF);
    chk("unmapped err", 32'h1, err);
    apb(1'b1, CDIO_OFS_ALL_LEVELS, 32'h0, 4'hF);
    chk("read-only err", 32'h1, err);
    apb(1'b1, CDIO_OFS_SOFT_WORD, {24'h0, ~exp_uo}, 4'h1);
    chk("strobe err", 32'h1, err);
    apb(1'b1, CDIO_OFS_PIN_PICK, 32'd12, 4'hF);
    apb(1'b1, CDIO_OFS_PIN_CFG, 32'h1, 4'hF);
    chk("bad line err", 32'h1, err);
    apb(1'b0, CDIO_OFS_SOFT_WORD, 32'h0, 4'hF);
    chk("word kept", exp_uo, rd[7:0]);
    chk("read ok", 32'h0, err);
    $display("test refusals done");
    give_verdict();
  end
endmodule : tb_camera_digital_io_lines
`default_nettype wire
